// File: hw/impp_pkg.sv
// Behaviour
// - 256-byte pages, 32-byte blocks, block-wide programming
// - Supply-level voltage pin at reset release enters programming
// - Programming logic runs from internal oscillator
// - Link acts as 7-bit addressed slave receiver
// - Acknowledge slave address 1010000, write direction; the code acknowledges the read direction too
// - Mode code 00000000 first, then command bytes
// - Command 01: take 32 bytes, erase, write block
// - Command 02: address then data, erase, write byte
// - Command 03: erase block chosen by top bits
// - Command 04: erase addressed byte in page
// - Command 05: address byte, then read one byte
// - Command 09: erase whole memory
// - Command 0b: write 32 bytes without erasing
// - Command 0c: load page pointer from next byte
// - Command 0d: return current byte, post-increment address
// - Command 0f: block pointer modulo 8, page carry
// - Command 13: return status byte with lock flag
// - Four-bit code corrects single-bit errors on read
// - Locked memory refuses external reads
// - Hold clock low during block programming time
// - Pointers start at page 48, block 3, byte 0
// - Erase clears bits to zero
package impp_pkg;
  localparam logic [6:0] SLAVE_ADDR = 7'h50;
  localparam logic [7:0] MODE_CODE = 8'h00;
  localparam logic [7:0] CMD_BLK_ERASE_WRITE = 8'h01;
  localparam logic [7:0] CMD_BYTE_ERASE_WRITE = 8'h02;
  localparam logic [7:0] CMD_BLK_ERASE = 8'h03;
  localparam logic [7:0] CMD_BYTE_ERASE = 8'h04;
  localparam logic [7:0] CMD_ADDR_READ = 8'h05;
  localparam logic [7:0] CMD_ERASE_ALL = 8'h09;
  localparam logic [7:0] CMD_BLK_WRITE_NO_ERASE = 8'h0b;
  localparam logic [7:0] CMD_LOAD_PAGE = 8'h0c;
  localparam logic [7:0] CMD_SEQ_READ = 8'h0d;
  localparam logic [7:0] CMD_ADV_BLOCK = 8'h0f;
  localparam logic [7:0] CMD_STATUS = 8'h13;
  localparam logic [5:0] BLOCK_BYTES = 6'h20;
  localparam logic [7:0] INIT_PAGE = 8'h30;
  localparam logic [2:0] INIT_BLOCK = 3'h3;
  localparam logic [4:0] INIT_BYTE = 5'h00;
  localparam int STAT_LOCKED = 0;
  localparam int STAT_ECC = 1;
  localparam int STAT_BAD_CMD = 2;
  localparam int CLK_MHZ = 250;
  localparam int WRITE_TIME_US = 2500;
  localparam int ERASE_TIME_US = 2000;
  localparam int WRITE_CYC = WRITE_TIME_US * CLK_MHZ;
  localparam int ERASE_CYC = ERASE_TIME_US * CLK_MHZ;
  // Memory location: page, block and byte within block
  typedef struct packed {
    logic [7:0] page;
    logic [2:0] block;
    logic [4:0] byte_idx;
  } impp_ptr_s;
  typedef enum logic [1:0] {K_OVERWRITE, K_SETBITS, K_CLEAR} impp_kind_e;
  typedef struct packed {
    logic [15:0] base;
    logic [15:0] last;
    impp_kind_e kind;
  } impp_op_s;
endpackage

// File: hw/impp_port.sv
`timescale 1ns/1ps
module impp_port
  import impp_pkg::*;
#(
  parameter int MEM_AW = 14,
  parameter int WRITE_CYCLES = WRITE_CYC,
  parameter int ERASE_CYCLES = ERASE_CYC
)(
  input wire logic clk,
  input wire logic rst,
  input wire logic vpp_in,
  input wire logic scl_in,
  output logic scl_out,
  output logic scl_oe,
  input wire logic sda_in,
  output logic sda_out,
  output logic sda_oe,
  output logic run_mode
);
  // clk is the internal oscillator; no external crystal is used here
  typedef enum {S_IDLE, S_ADDR, S_AACK, S_RX, S_RWAIT, S_RACK, S_HOLD, S_TX, S_TACK} impp_slv_e;
  typedef enum {P_MODE, P_CMD, P_DATA, P_OP} impp_prg_e;

  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  // ----------------------------------------
  // Error-correcting code
  // ----------------------------------------
  function automatic logic [3:0] ecc_gen(input logic [7:0] d);
    ecc_gen = {d[4] ^ d[5] ^ d[6] ^ d[7], d[1] ^ d[2] ^ d[3] ^ d[7],
               d[0] ^ d[2] ^ d[3] ^ d[5] ^ d[6], d[0] ^ d[1] ^ d[3] ^ d[4] ^ d[6]};
  endfunction

  function automatic logic [3:0] ecc_syn(input logic [11:0] w);
    ecc_syn = w[11:8] ^ ecc_gen(w[7:0]);
  endfunction

  // Syndrome equals the bit position of the flipped bit
  function automatic logic [7:0] ecc_fix(input logic [11:0] w);
    case (ecc_syn(w))
      4'h3: ecc_fix = w[7:0] ^ 8'h01;
      4'h5: ecc_fix = w[7:0] ^ 8'h02;
      4'h6: ecc_fix = w[7:0] ^ 8'h04;
      4'h7: ecc_fix = w[7:0] ^ 8'h08;
      4'h9: ecc_fix = w[7:0] ^ 8'h10;
      4'ha: ecc_fix = w[7:0] ^ 8'h20;
      4'hb: ecc_fix = w[7:0] ^ 8'h40;
      4'hc: ecc_fix = w[7:0] ^ 8'h80;
      default: ecc_fix = w[7:0];
    endcase
  endfunction

  function automatic impp_op_s mk_op(input logic [15:0] base, input logic [15:0] last,
                                     input impp_kind_e kind);
    mk_op = '{base: base, last: last, kind: kind};
  endfunction

  // ----------------------------------------
  // Pin synchronisers and mode entry
  // ----------------------------------------
  logic scl_s1, scl_s2, scl_d, sda_s1, sda_s2, sda_d, vpp_s1, vpp_s2;
  logic prog_mode, captured;
  logic scl_rise, scl_fall, bus_start, bus_stop;

  // Two flops per pin; SCL and SDA also keep a third stage for edge detection
  always_ff @(posedge clk)
  begin
    scl_s1 <= scl_in;
    scl_s2 <= scl_s1;
    scl_d <= scl_s2;
    sda_s1 <= sda_in;
    sda_s2 <= sda_s1;
    sda_d <= sda_s2;
    vpp_s1 <= vpp_in;
    vpp_s2 <= vpp_s1;
  end

  // Voltage pin is caught once, in the first cycle after reset release
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      captured <= 1'b0;
      prog_mode <= 1'b0;
      run_mode <= 1'b1;
    end
    else if (!captured)
    begin
      captured <= 1'b1;
      prog_mode <= vpp_s2;
      run_mode <= ~vpp_s2;
    end
  end

  a_mode_entry: assert property ($rose(prog_mode) |-> $past(rst, 2))
    else $error("programming mode entered outside reset release");

  assign scl_out = 1'b0;
  assign sda_out = 1'b0;
  assign scl_rise = scl_s2 & ~scl_d;
  assign scl_fall = ~scl_s2 & scl_d;
  assign bus_start = scl_s2 & scl_d & sda_d & ~sda_s2;
  assign bus_stop = scl_s2 & scl_d & ~sda_d & sda_s2;

  // ----------------------------------------
  // Receive buffer, two entries
  // ----------------------------------------
  logic [7:0] fifo_q [2];
  logic fifo_wp, fifo_rp, push, pop, fifo_ready, busy;
  logic [1:0] fifo_cnt;
  logic [7:0] fbyte, shreg;
  impp_prg_e pst;

  assign fifo_ready = fifo_cnt != 2'h2;
  assign fbyte = fifo_q[fifo_rp];
  assign pop = (fifo_cnt != 2'h0) && (pst != P_OP);
  // Busy until queued bytes are consumed and any timed operation ends
  assign busy = (pst == P_OP) || (fifo_cnt != 2'h0);

  always_ff @(posedge clk)
  begin
    if (push)
      fifo_q[fifo_wp] <= shreg;
  end

  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      fifo_wp <= 1'b0;
      fifo_rp <= 1'b0;
      fifo_cnt <= 2'h0;
    end
    else
    begin
      if (push)
        fifo_wp <= ~fifo_wp;
      if (pop)
        fifo_rp <= ~fifo_rp;
      fifo_cnt <= fifo_cnt + {1'b0, push} - {1'b0, pop};
    end
  end

  // ----------------------------------------
  // Serial slave
  // ----------------------------------------
  impp_slv_e st;
  logic [3:0] cnt;
  logic rw;
  logic [7:0] txsh, tx_byte;

  assign push = (st == S_RWAIT) && fifo_ready;

  // Open-drain: oe high pulls the line low
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      st <= S_IDLE;
      cnt <= 4'h0;
      shreg <= 8'h00;
      txsh <= 8'h00;
      rw <= 1'b0;
      sda_oe <= 1'b0;
      scl_oe <= 1'b0;
    end
    else if (bus_start)
    begin
      st <= S_ADDR;
      cnt <= 4'h0;
      sda_oe <= 1'b0;
      scl_oe <= 1'b0;
    end
    else if (bus_stop)
    begin
      st <= S_IDLE;
      sda_oe <= 1'b0;
      scl_oe <= 1'b0;
    end
    else
    begin
      case (st)
        S_ADDR, S_RX:
        begin
          if (scl_rise)
          begin
            shreg <= {shreg[6:0], sda_s2};
            cnt <= cnt + 4'h1;
          end
          else if (scl_fall && cnt == 4'h8)
          begin
            if (st == S_RX)
            begin
              scl_oe <= 1'b1; // Hold SCL until the buffer has room
              st <= S_RWAIT;
            end
            else if (prog_mode && shreg[7:1] == SLAVE_ADDR)
            begin
              sda_oe <= 1'b1;
              rw <= shreg[0];
              st <= S_AACK;
            end
            else
              st <= S_IDLE;
          end
        end
        S_RWAIT:
        begin
          if (fifo_ready)
          begin
            scl_oe <= 1'b0;
            sda_oe <= 1'b1;
            st <= S_RACK;
          end
        end
        S_AACK:
        begin
          if (scl_fall)
          begin
            cnt <= 4'h0;
            txsh <= tx_byte;
            sda_oe <= rw & ~tx_byte[7];
            st <= rw ? S_TX : S_RX;
          end
        end
        S_RACK:
        begin
          if (scl_fall)
          begin
            sda_oe <= 1'b0;
            cnt <= 4'h0;
            scl_oe <= busy;
            st <= busy ? S_HOLD : S_RX;
          end
        end
        S_HOLD:
        begin
          if (!busy)
          begin
            scl_oe <= 1'b0;
            st <= S_RX;
          end
        end
        S_TX:
        begin
          if (scl_rise)
            cnt <= cnt + 4'h1;
          else if (scl_fall && cnt == 4'h8)
          begin
            sda_oe <= 1'b0;
            st <= S_TACK;
          end
          else if (scl_fall)
          begin
            sda_oe <= ~txsh[6];
            txsh <= {txsh[6:0], 1'b0};
          end
        end
        S_TACK:
        begin
          if (scl_rise)
            st <= sda_s2 ? S_IDLE : S_AACK; // Ack from master repeats the byte
        end
        default: st <= S_IDLE;
      endcase
    end
  end

  sequence s_own_addr;
    st == S_ADDR && scl_fall && cnt == 4'h8 && !bus_start && !bus_stop && prog_mode;
  endsequence

  a_ack_own_addr: assert property (s_own_addr and shreg[7:1] == SLAVE_ADDR |=> sda_oe)
    else $error("own address not acknowledged");
  a_skip_other: assert property (s_own_addr and shreg[7:1] != SLAVE_ADDR |=> !sda_oe && st == S_IDLE)
    else $error("foreign address acknowledged");
  a_rx_byte_ack: assert property (st == S_RWAIT && fifo_ready && !bus_start && !bus_stop
                                  |=> sda_oe && !scl_oe)
    else $error("received byte not acknowledged");
  a_hold_busy: assert property (st == S_HOLD && pst == P_OP |-> scl_oe)
    else $error("clock released during programming");

  // ----------------------------------------
  // Command interpreter and memory
  // ----------------------------------------
  logic [11:0] mem [2**MEM_AW];
  impp_ptr_s ptr, lock_ptr;
  impp_op_s op;
  logic [7:0] cmd, op_data, rd_data, wr_src, wr_data;
  logic [7:0] blk_buf [32];
  logic [5:0] argc, nargs;
  logic [15:0] op_idx, rd_addr, wr_addr;
  logic [23:0] timer, op_cyc;
  logic wr_en, wr_done, locked, ecc_err, bad_cmd;
  logic [7:0] status;

  assign lock_ptr = '{page: INIT_PAGE, block: INIT_BLOCK, byte_idx: INIT_BYTE};
  assign locked = ecc_fix(mem[lock_ptr[MEM_AW-1:0]]) != 8'h00;
  assign wr_addr = op.base + op_idx;
  assign rd_addr = (pst == P_OP) ? wr_addr : (pst == P_DATA) ? {ptr.page, fbyte} : ptr;
  assign rd_data = ecc_fix(mem[rd_addr[MEM_AW-1:0]]);
  assign wr_en = (pst == P_OP) && !wr_done;
  assign wr_src = (op.last == 16'h0) ? op_data : blk_buf[op_idx[4:0]];
  assign wr_data = (op.kind == K_CLEAR) ? 8'h00 :
                   (op.kind == K_SETBITS) ? (rd_data | wr_src) : wr_src;
  assign op_cyc = (op.kind == K_OVERWRITE) ? 24'(ERASE_CYCLES + WRITE_CYCLES) :
                  (op.kind == K_SETBITS) ? 24'(WRITE_CYCLES) : 24'(ERASE_CYCLES);
  assign status = {5'h00, bad_cmd, ecc_err, locked};

  // Argument count of the command being collected
  always_comb
  begin
    nargs = nargs_of(cmd);
  end

  always_ff @(posedge clk)
  begin
    if (wr_en)
      mem[wr_addr[MEM_AW-1:0]] <= {ecc_gen(wr_data), wr_data};
  end

  always_ff @(posedge clk)
  begin
    if (pop && pst == P_DATA)
      blk_buf[argc[4:0]] <= fbyte;
  end

  // A timed operation ends only after every cell is written and the time has run
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      pst <= P_MODE;
      ptr <= '{page: INIT_PAGE, block: INIT_BLOCK, byte_idx: INIT_BYTE};
      cmd <= 8'h00;
      argc <= 6'h00;
      op <= mk_op(16'h0, 16'h0, K_CLEAR);
      op_data <= 8'h00;
      op_idx <= 16'h0;
      wr_done <= 1'b0;
      timer <= 24'h0;
      tx_byte <= 8'h00;
      ecc_err <= 1'b0;
      bad_cmd <= 1'b0;
    end
    else
    begin
      case (pst)
        P_MODE:
          if (pop && fbyte == MODE_CODE)
            pst <= P_CMD;
        P_CMD:
          if (pop)
          begin
            cmd <= fbyte;
            argc <= 6'h00;
            op_idx <= 16'h0;
            wr_done <= 1'b0;
            timer <= 24'h0;
            case (fbyte)
              CMD_BLK_ERASE_WRITE, CMD_BYTE_ERASE_WRITE, CMD_BLK_ERASE, CMD_BYTE_ERASE,
              CMD_ADDR_READ, CMD_BLK_WRITE_NO_ERASE, CMD_LOAD_PAGE:
                pst <= P_DATA;
              CMD_ERASE_ALL:
              begin
                op <= mk_op(16'h0, 16'((1 << MEM_AW) - 1), K_CLEAR);
                pst <= P_OP;
              end
              CMD_SEQ_READ:
              begin
                tx_byte <= locked ? 8'h00 : rd_data;
                ecc_err <= ecc_err | (ecc_syn(mem[rd_addr[MEM_AW-1:0]]) != 4'h0);
                ptr <= ptr + 16'h1;
              end
              CMD_ADV_BLOCK:
              begin
                ptr.block <= ptr.block + 3'h1;
                if (ptr.block == 3'h7)
                  ptr.page <= ptr.page + 8'h1;
              end
              CMD_STATUS: tx_byte <= status;
              default: bad_cmd <= 1'b1;
            endcase
          end
        P_DATA:
          if (pop)
          begin
            argc <= argc + 6'h1;
            if (argc == nargs - 6'h1)
            begin
              pst <= P_OP;
              op_data <= fbyte;
              case (cmd)
                CMD_BLK_ERASE_WRITE:
                  op <= mk_op({ptr.page, ptr.block, 5'h00}, 16'h1f, K_OVERWRITE);
                CMD_BLK_WRITE_NO_ERASE:
                  op <= mk_op({ptr.page, ptr.block, 5'h00}, 16'h1f, K_SETBITS);
                CMD_BYTE_ERASE_WRITE:
                  op <= mk_op({ptr.page, blk_buf[0]}, 16'h0, K_OVERWRITE);
                CMD_BLK_ERASE:
                  op <= mk_op({ptr.page, fbyte[7:5], 5'h00}, 16'h1f, K_CLEAR);
                CMD_BYTE_ERASE:
                  op <= mk_op({ptr.page, fbyte}, 16'h0, K_CLEAR);
                CMD_ADDR_READ:
                begin
                  tx_byte <= locked ? 8'h00 : rd_data;
                  pst <= P_CMD;
                end
                default:
                begin
                  ptr.page <= fbyte;
                  pst <= P_CMD;
                end
              endcase
            end
          end
        P_OP:
        begin
          timer <= timer + 24'h1;
          if (!wr_done)
          begin
            op_idx <= op_idx + 16'h1;
            wr_done <= op_idx == op.last;
          end
          else if (timer >= op_cyc)
            pst <= P_CMD;
        end
        default: pst <= P_CMD;
      endcase
    end
  end

  function automatic logic [5:0] nargs_of(input logic [7:0] c);
    case (c)
      CMD_BLK_ERASE_WRITE, CMD_BLK_WRITE_NO_ERASE: nargs_of = BLOCK_BYTES;
      CMD_BYTE_ERASE_WRITE: nargs_of = 6'h02;
      default: nargs_of = 6'h01;
    endcase
  endfunction

  a_init_ptr: assert property ($past(rst) |-> ptr == lock_ptr && pst == P_MODE)
    else $error("pointers not at lock byte after reset");
  a_mode_code: assert property (pst == P_MODE && pop && fbyte != MODE_CODE |=> pst == P_MODE)
    else $error("command taken before mode code");
  a_block_wrap: assert property (pst == P_CMD && pop && fbyte == CMD_ADV_BLOCK && ptr.block == 3'h7
                                 |=> ptr.block == 3'h0 && ptr.page == $past(ptr.page) + 8'h1)
    else $error("block wrap did not carry into page");
  a_lock_read: assert property (pst == P_CMD && pop && fbyte == CMD_SEQ_READ && locked
                                |=> tx_byte == 8'h00)
    else $error("locked memory contents returned");
  a_op_time: assert property (pst == P_OP && timer < op_cyc |=> pst == P_OP)
    else $error("operation ended before its time");
  a_erase_zero: assert property (wr_en && op.kind == K_CLEAR
                                 |=> mem[$past(wr_addr[MEM_AW-1:0])] == 12'h000)
    else $error("erased cell not zero");
endmodule

// File: tb/impp_master.sv
`timescale 1ns/1ps
module impp_master
(
  input wire logic clk,
  input wire logic scl_wire,
  input wire logic sda_wire,
  output logic scl_low,
  output logic sda_low
);
  // Cycles spent waiting for SCL high on the last release
  int stretch = 0;

  // ---------------------------------------------
  // Line timing
  // ---------------------------------------------
  // Both lines released at time zero, pull-ups idle them high
  initial
  begin
    scl_low = 1'b0;
    sda_low = 1'b0;
  end

  // A quarter bit, about 132 ns a bit, changes land on a clock edge
  task automatic quarter();
    #29;
    @(posedge clk);
  endtask

  // Release SCL and wait, bounded, while the device holds it low
  task automatic rise();
    scl_low <= 1'b0;
    stretch = 0;
    do
    begin
      @(posedge clk);
      stretch++;
    end while (scl_wire !== 1'b1 && stretch < 40000);
    quarter();
  endtask

  // SDA only moves while SCL is low, so no false start or stop
  task automatic bit_xfer(input logic b, output logic r);
    sda_low <= ~b;
    quarter();
    rise();
    r = sda_wire;
    quarter();
    scl_low <= 1'b1;
    quarter();
  endtask

  // ---------------------------------------------
  // Frames
  // ---------------------------------------------
  // Start from an idle bus only: every turn of direction goes via stop
  task automatic start();
    sda_low <= 1'b1;
    quarter();
    scl_low <= 1'b1;
    quarter();
  endtask

  task automatic stop();
    sda_low <= 1'b1;
    quarter();
    rise();
    sda_low <= 1'b0;
    quarter();
    quarter();
  endtask

  // Byte out MSB first, SDA released for the ninth bit
  task automatic send(input logic [7:0] b, output logic ack);
    logic r;
    for (int i = 7; i >= 0; i--)
      bit_xfer(b[i], r);
    bit_xfer(1'b1, r);
    ack = ~r;
  endtask

  // Byte in, then ack or not-ack from the programmer
  task automatic recv(input logic ack, output logic [7:0] b);
    logic r;
    for (int i = 7; i >= 0; i--)
    begin
      bit_xfer(1'b1, r);
      b[i] = r;
    end
    bit_xfer(~ack, r);
  endtask
endmodule

// File: tb/impp_port_tb.sv
`timescale 1ns/1ps
module impp_port_tb
  import impp_pkg::*;
;
  localparam int WC = 200;
  localparam int EC = 150;
  // Master's own cycles from the last bit's fall to its stop releasing SCL
  localparam int LAG = 49;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic vpp_in = 1'b0;
  logic scl_low, sda_low, scl_out, scl_oe, sda_out, sda_oe, run_mode;
  logic scl_wire, sda_wire, ack;
  logic [7:0] d, pg, off;
  logic [7:0] blk [32];
  logic [7:0] shadow [logic [15:0]];
  int err_count = 0;
  int compares = 0;
  int cyc = 0;

  // ---------------------------------------------
  // Clock, wires and instances
  // ---------------------------------------------
  always #2 clk = ~clk;
  // Open-drain wires with pull-ups: low while any party pulls
  assign scl_wire = ~((scl_oe & ~scl_out) | scl_low);
  assign sda_wire = ~((sda_oe & ~sda_out) | sda_low);

  impp_port #(.MEM_AW(14), .WRITE_CYCLES(WC), .ERASE_CYCLES(EC)) u_impp_port (
    .clk(clk), .rst(rst), .vpp_in(vpp_in), .scl_in(scl_wire), .scl_out(scl_out),
    .scl_oe(scl_oe), .sda_in(sda_wire), .sda_out(sda_out), .sda_oe(sda_oe),
    .run_mode(run_mode)
  );
  impp_master u_impp_master (
    .clk(clk), .scl_wire(scl_wire), .sda_wire(sda_wire), .scl_low(scl_low),
    .sda_low(sda_low)
  );

  // Hang guard, a little above the expected run length
  always @(posedge clk)
  begin
    cyc++;
    if (cyc == 95000)
    begin
      err_count++;
      print_verdict();
    end
  end

  // ---------------------------------------------
  // Checking and expectations
  // ---------------------------------------------
  task automatic print_verdict();
    $display("Counts: %0d compares, %0d mismatches", compares, err_count);
    if (err_count == 0 && compares > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask

  task automatic check(input logic [7:0] seen, input logic [7:0] exp, input string what);
    compares++;
    if (seen !== exp)
    begin
      err_count++;
      $display("MISMATCH at %0t: %s seen %h expected %h", $time, what, seen, exp);
    end
  endtask

  function automatic logic [15:0] loc(input logic [7:0] page, input logic [7:0] o);
    return {page, o};
  endfunction

  // Erased cells read as zero; never written cells count as erased
  function automatic logic [7:0] raw(input logic [15:0] a);
    return shadow.exists(a) ? shadow[a] : 8'h00;
  endfunction

  // A nonzero lock byte hides the contents from reads
  function automatic logic [7:0] exp_at(input logic [15:0] a);
    return (raw(loc(INIT_PAGE, {INIT_BLOCK, INIT_BYTE})) != 8'h00) ? 8'h00 : raw(a);
  endfunction

  // ---------------------------------------------
  // Link sequences
  // ---------------------------------------------
  task automatic do_reset();
    @(posedge clk);
    rst <= 1'b1;
    vpp_in <= 1'b1;
    repeat (12) @(posedge clk);
    check({7'h00, run_mode}, 8'h01, "run mode in reset");
    rst <= 1'b0;
    repeat (3) @(posedge clk);
    check({7'h00, run_mode}, 8'h00, "programming mode");
  endtask

  task automatic wr(input logic [7:0] b);
    u_impp_master.send(b, ack);
    check({7'h00, ack}, 8'h01, "byte ack");
  endtask

  task automatic enter();
    u_impp_master.start();
    wr({SLAVE_ADDR, 1'b0});
    wr(MODE_CODE);
  endtask

  // Turn round for one byte in, then reopen in the write direction
  task automatic rd(input logic [7:0] c, input bit na, input logic [7:0] a);
    wr(c);
    if (na)
      wr(a);
    u_impp_master.stop();
    u_impp_master.start();
    wr({SLAVE_ADDR, 1'b1});
    u_impp_master.recv(1'b0, d);
    u_impp_master.stop();
    u_impp_master.start();
    wr({SLAVE_ADDR, 1'b0});
  endtask

  task automatic rd_at(input logic [7:0] page, input logic [7:0] o);
    wr(CMD_LOAD_PAGE);
    wr(page);
    rd(CMD_ADDR_READ, 1'b1, o);
    check(d, exp_at(loc(page, o)), "addressed read");
  endtask

  task automatic byte_wr(input logic [7:0] page, input logic [7:0] o, input logic [7:0] v);
    wr(CMD_LOAD_PAGE);
    wr(page);
    wr(CMD_BYTE_ERASE_WRITE);
    wr(o);
    wr(v);
    shadow[loc(page, o)] = v;
  endtask

  // Block of 32, then the clock is held for the whole programming time
  task automatic blk_write(input logic [7:0] c, input logic [15:0] base);
    int t;
    t = (c == CMD_BLK_ERASE_WRITE) ? EC + WC : WC;
    wr(c);
    for (int i = 0; i < 32; i++)
    begin
      wr(blk[i]);
      shadow[base + 16'(i)] = (c == CMD_BLK_ERASE_WRITE) ? blk[i] :
        (raw(base + 16'(i)) | blk[i]);
    end
    u_impp_master.stop();
    t = u_impp_master.stretch + LAG - t;
    check({7'h00, t >= -24 && t <= 64}, 8'h01, "block stretch");
    u_impp_master.start();
    wr({SLAVE_ADDR, 1'b0});
  endtask

  // ---------------------------------------------
  // Tests
  // ---------------------------------------------
  initial
  begin
    void'($urandom(32'h5900));
    // Foreign address, entry, erase-all and a clean status
    do_reset();
    u_impp_master.start();
    u_impp_master.send({SLAVE_ADDR ^ 7'h01, 1'b0}, ack);
    check({7'h00, ack}, 8'h00, "foreign address");
    u_impp_master.stop();
    // A byte other than the mode code is ignored
    u_impp_master.start();
    wr({SLAVE_ADDR, 1'b0});
    wr(8'h5a);
    wr(MODE_CODE);
    wr(CMD_ERASE_ALL);
    u_impp_master.stop();
    check({7'h00, u_impp_master.stretch + LAG >= 16384}, 8'h01, "erase-all stretch");
    u_impp_master.start();
    wr({SLAVE_ADDR, 1'b0});
    rd(CMD_STATUS, 1'b0, 8'h00);
    check(d & 8'h05, 8'h00, "status after erase");
    foreach (blk[i]) blk[i] = 8'($urandom);
    blk[0] = 8'h00; // Keep the lock byte clear for now
    blk_write(CMD_BLK_WRITE_NO_ERASE, loc(INIT_PAGE, {INIT_BLOCK, INIT_BYTE}));
    $display("Test entry and fast block done");
    // Second reset: pointer back at the lock byte, memory kept
    u_impp_master.stop();
    do_reset();
    enter();
    for (int i = 0; i < 2; i++)
    begin
      rd(CMD_SEQ_READ, 1'b0, 8'h00);
      check(d, blk[i], "sequential read");
    end
    repeat (5) wr(CMD_ADV_BLOCK);
    foreach (blk[i]) blk[i] = 8'($urandom);
    blk_write(CMD_BLK_ERASE_WRITE, loc(8'h31, 8'h00));
    rd_at(8'h31, 8'h00);
    rd_at(8'h31, 8'h1f);
    rd_at(8'h31, 8'h20);
    rd_at(INIT_PAGE, 8'h7f);
    $display("Test pointers and block write done");
    // Random single-byte writes, then erase of the last one
    for (int n = 0; n < 3; n++)
    begin
      pg = 8'($urandom_range(0, 31));
      off = 8'($urandom);
      byte_wr(pg, off, 8'($urandom));
      rd_at(pg, off);
    end
    wr(CMD_BYTE_ERASE);
    wr(off);
    shadow[loc(pg, off)] = 8'h00;
    rd_at(pg, off);
    // Block erase picked by the top three bits of its argument
    byte_wr(pg, 8'h45, 8'($urandom) | 8'h01);
    byte_wr(pg, 8'h25, 8'($urandom) | 8'h01);
    wr(CMD_BLK_ERASE);
    wr(8'h40 | 8'($urandom_range(0, 31)));
    for (int i = 8'h40; i < 8'h60; i++)
      shadow[loc(pg, 8'(i))] = 8'h00;
    rd_at(pg, 8'h45);
    rd_at(pg, 8'h25);
    $display("Test byte and block erase done");
    // Unknown code, then a lock byte hides the contents
    wr(8'h07);
    byte_wr(INIT_PAGE, 8'h60, 8'h5a);
    rd(CMD_STATUS, 1'b0, 8'h00);
    check(d & 8'h05, 8'h05, "status locked");
    rd(CMD_SEQ_READ, 1'b0, 8'h00);
    check(d, exp_at(loc(8'h31, 8'h02)), "locked sequential read");
    rd_at(8'h31, 8'h00);
    u_impp_master.stop();
    $display("Test lock and status done");
    print_verdict();
  end
endmodule
